// ### sim/exec_checker_assertions.sv
/*
  port checker for the execution block.
  assumes a bind onto cpu_branch_inc_or_shift_ops, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module exec_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [14:0] program_counter,
  input wire logic [7:0] accumulator,
  input wire logic carry_flag,
  input wire logic zero_flag
);
  // ****************************************
  // properties
  // ****************************************
  logic take, br, fl;
  logic [5:0] op;
  assign take = instr_valid && instr_ready;
  assign op = instr_word[13:8];
  assign br = take && instr_word[13:11] == core_exec_pkg::OP_ABSOLUTE_BRANCH;
  assign fl = !(bus_wr && bus_addr == core_exec_pkg::ADDR_STATUS);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  take_done_a: assert property (take |=> instr_done)
    else $error("done missing after take");
  idle_done_a: assert property (!take |=> !instr_done)
    else $error("done without take");
  branch_low_a: assert property (br |=> program_counter[10:0] == $past(instr_word[10:0]))
    else $error("branch low pc wrong");
  branch_stall_a: assert property (br |=> !instr_ready ##1 instr_ready)
    else $error("branch not two cycles");
  branch_flags_a: assert property (br && fl |=> $stable(carry_flag) && $stable(zero_flag))
    else $error("branch changed flags");
  skip_flags_a: assert property (take && op == core_exec_pkg::OP_INCREMENT_SKIP_ZERO
    && fl |=> $stable(carry_flag) && $stable(zero_flag))
    else $error("skip changed flags");
  skip_pc_a: assert property (take && op == core_exec_pkg::OP_INCREMENT_SKIP_ZERO
    |=> (program_counter == $past(program_counter) + 15'h0002) == !instr_ready)
    else $error("skip pc and stall disagree");
  or_literal_a: assert property (take && op == core_exec_pkg::OP_OR_LITERAL_ACCUMULATOR
    |=> accumulator == ($past(accumulator) | $past(instr_word[7:0]))
    && zero_flag == (accumulator == 8'h00))
    else $error("or literal result wrong");
  inc_pc_a: assert property (take && op == core_exec_pkg::OP_FILE_INCREMENT
    |=> program_counter == $past(program_counter) + 15'h0001)
    else $error("increment pc step wrong");
  rdata_idle_a: assert property (!bus_rd |=> bus_rdata == 8'h00)
    else $error("read data not cleared");
  cover property (br);
  cover property (take && op == core_exec_pkg::OP_LOGICAL_LEFT_SHIFT);
  cover property (take && op == core_exec_pkg::OP_INCREMENT_SKIP_ZERO ##1 !instr_ready);
endmodule
bind cpu_branch_inc_or_shift_ops exec_checker chk_i (.clk, .resetn, .instr_valid,
  .instr_word, .instr_ready, .instr_done, .bus_addr, .bus_wr, .bus_rd, .bus_rdata,
  .program_counter, .accumulator, .carry_flag, .zero_flag);
`default_nettype wire

// ### sim/tb_top.sv
/*
  self-checking bench for the execution block.
  assumes the bench alone drives every input.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // bench
  // ****************************************
  logic clk = 0, resetn = 0, instr_valid = 0, bus_wr = 0, bus_rd = 0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, v;
  logic instr_ready, instr_done, carry_flag, zero_flag;
  logic [7:0] bus_rdata, accumulator;
  logic [14:0] program_counter;
  int mismatches = 0, checked = 0, cycles = 0;
  cpu_branch_inc_or_shift_ops dut (.clk(clk), .resetn(resetn), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .instr_done(instr_done),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .program_counter(program_counter), .accumulator(accumulator),
    .carry_flag(carry_flag), .zero_flag(zero_flag));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop;
    end
  end
  task automatic chk(input string n, input logic [14:0] s, input logic [14:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_rd <= 1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 0;
    #1 v = bus_rdata;
  endtask
  task automatic ex(input logic [13:0] w);
    @(negedge clk);
    while (instr_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    instr_valid <= 1;
    instr_word <= w;
    @(posedge clk);
    instr_valid <= 0;
    #1 chk("done", instr_done, 1);
  endtask
  task automatic t_inc;
    wr(8'h05, 8'h41);
    ex({6'h0a, 1'b0, 7'h05});
    chk("inc acc", accumulator, 8'h42);
    chk("inc z", zero_flag, 0);
    chk("inc pc", program_counter, 15'h0001);
    wr(8'h06, 8'hff);
    ex({6'h0a, 1'b1, 7'h06});
    chk("inc z1", zero_flag, 1);
    rd(8'h06);
    chk("inc file", v, 8'h00);
    chk("inc acc kept", accumulator, 8'h42);
  endtask
  task automatic t_skip;
    wr(8'h81, 8'h00);
    wr(8'h07, 8'hff);
    ex({6'h0f, 1'b1, 7'h07});
    chk("skip ready", instr_ready, 0);
    chk("skip pc", program_counter, 15'h0004);
    @(posedge clk);
    #1 chk("skip ready1", instr_ready, 1);
    chk("skip z", zero_flag, 0);
    rd(8'h07);
    chk("skip file", v, 8'h00);
    wr(8'h81, 8'h03);
    wr(8'h08, 8'h10);
    ex({6'h0f, 1'b0, 7'h08});
    chk("noskip acc", accumulator, 8'h11);
    chk("noskip ready", instr_ready, 1);
    chk("noskip pc", program_counter, 15'h0005);
    chk("noskip z", zero_flag, 1);
    chk("noskip c", carry_flag, 1);
  endtask
  task automatic t_or;
    ex({6'h38, 8'ha0});
    chk("orl acc", accumulator, 8'hb1);
    chk("orl z", zero_flag, 0);
    wr(8'h80, 8'h00);
    ex({6'h38, 8'h00});
    chk("orl z1", zero_flag, 1);
    wr(8'h09, 8'h0c);
    wr(8'h80, 8'h30);
    ex({6'h04, 1'b1, 7'h09});
    chk("orf z", zero_flag, 0);
    chk("orf acc", accumulator, 8'h30);
    chk("orf c", carry_flag, 1);
    rd(8'h09);
    chk("orf file", v, 8'h3c);
  endtask
  task automatic t_lsl;
    wr(8'h81, 8'h03);
    wr(8'h0a, 8'h40);
    ex({6'h35, 1'b0, 7'h0a});
    chk("lsl acc", accumulator, 8'h80);
    chk("lsl c", carry_flag, 0);
    chk("lsl z0", zero_flag, 0);
    wr(8'h81, 8'h02);
    wr(8'h0b, 8'h81);
    ex({6'h35, 1'b1, 7'h0b});
    chk("lsl c1", carry_flag, 1);
    chk("lsl z", zero_flag, 0);
    rd(8'h0b);
    chk("lsl file", v, 8'h02);
  endtask
  task automatic t_branch;
    wr(8'h82, 8'h55);
    ex({3'h5, 11'h123});
    chk("br pc", program_counter, 15'h5123);
    chk("br ready", instr_ready, 0);
    chk("br c", carry_flag, 1);
    chk("br z", zero_flag, 0);
    rd(8'h83);
    chk("br pcl", v, 8'h23);
    rd(8'h90);
    chk("unmapped", v, 8'h00);
    ex(14'h0000);
    chk("nop pc", program_counter, 15'h5124);
    chk("nop acc", accumulator, 8'h80);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1;
    #1 chk("pc reset", program_counter, 15'h0000);
    chk("acc reset", accumulator, 8'h00);
    t_inc;
    t_skip;
    t_or;
    t_lsl;
    t_branch;
    report_and_stop;
  end
endmodule
`default_nettype wire

// ### verilog/core_exec_pkg.sv
/*
  constants for the branch, increment, or and shift execution block.
  assumes one 100 MHz core clock and a 14-bit instruction word.
*/
`default_nettype none
package core_exec_pkg;

  // ****************************************
  // instruction fields
  // ****************************************
  localparam int OP_MSB = 13;
  localparam int OP_LSB = 8;
  localparam int BR_MSB = 13;
  localparam int BR_LSB = 11;
  localparam int DEST_POS = 7;
  localparam int FILE_MSB = 6;
  localparam int LIT11_MSB = 10;
  localparam int LIT8_MSB = 7;
  localparam int LATCH_HI = 6;
  localparam int LATCH_LO = 3;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [5:0] OP_FILE_INCREMENT = 6'h0a;
  localparam logic [5:0] OP_INCREMENT_SKIP_ZERO = 6'h0f;
  localparam logic [5:0] OP_OR_ACCUMULATOR_FILE = 6'h04;
  localparam logic [5:0] OP_LOGICAL_LEFT_SHIFT = 6'h35;
  localparam logic [5:0] OP_OR_LITERAL_ACCUMULATOR = 6'h38;
  localparam logic [2:0] OP_ABSOLUTE_BRANCH = 3'h5;

  // ****************************************
  // register port map
  // ****************************************
  localparam logic [7:0] ADDR_FILE_LAST = 8'h7f;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'h80;
  localparam logic [7:0] ADDR_STATUS = 8'h81;
  localparam logic [7:0] ADDR_PC_LATCH = 8'h82;
  localparam logic [7:0] ADDR_PC_LOW = 8'h83;
  localparam logic [7:0] ADDR_PC_HIGH = 8'h84;
  localparam int STATUS_ZERO_POS = 1;
  localparam int STATUS_CARRY_POS = 0;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [6:0] LATCH_RESET = 7'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [14:0] PC_STEP = 15'h0001;
  localparam logic [14:0] PC_SKIP_STEP = 15'h0002;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam int FILE_DEPTH = 128;

  typedef enum logic [0:0] {
    EXEC_STATE = 1'b0,
    FLUSH_STATE = 1'b1
  } exec_state_type;

endpackage
`default_nettype wire

// ### verilog/cpu_branch_inc_or_shift_ops.sv
/*
  execution of absolute branch, file increment, increment-and-skip,
  or with literal or file, and logical left shift.
  assumes instructions arrive on the core clock with a valid strobe
  and are taken only while instr_ready is high.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_branch_inc_or_shift_ops (
  input wire logic clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  output logic instr_done,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic [14:0] program_counter,
  output logic [7:0] accumulator,
  output logic carry_flag,
  output logic zero_flag
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0] file_mem [0:core_exec_pkg::FILE_DEPTH-1];
  logic [7:0] acc_reg;
  logic carry_reg;
  logic zero_reg;
  logic [6:0] latch_reg;
  logic [14:0] pc_reg;
  core_exec_pkg::exec_state_type state_reg;
  core_exec_pkg::exec_state_type state_next;
  logic ready_reg;
  logic done_reg;
  logic [7:0] rdata_reg;

  // ****************************************
  // decode
  // ****************************************
  logic take;
  logic [5:0] opcode;
  logic [6:0] file_addr;
  logic dest_file;
  logic [7:0] operand;
  logic [7:0] result;
  logic write_acc;
  logic write_file;
  logic set_zero;
  logic set_carry;
  logic carry_value;
  logic branch;
  logic skip;
  logic [14:0] pc_next;
  logic bus_wr_acc;
  logic bus_wr_status;
  logic bus_wr_latch;
  logic bus_wr_file;
  logic [7:0] read_value;

  assign take = instr_valid && ready_reg;
  assign opcode = instr_word[core_exec_pkg::OP_MSB:core_exec_pkg::OP_LSB];
  assign file_addr = instr_word[core_exec_pkg::FILE_MSB:0];
  assign dest_file = instr_word[core_exec_pkg::DEST_POS];
  assign operand = file_mem[file_addr];

  // ****************************************
  // register port write decode
  // ****************************************
  assign bus_wr_acc = bus_wr && (bus_addr == core_exec_pkg::ADDR_ACCUMULATOR);
  assign bus_wr_status = bus_wr && (bus_addr == core_exec_pkg::ADDR_STATUS);
  assign bus_wr_latch = bus_wr && (bus_addr == core_exec_pkg::ADDR_PC_LATCH);
  assign bus_wr_file = bus_wr && (bus_addr <= core_exec_pkg::ADDR_FILE_LAST);

  always_comb begin
    result = core_exec_pkg::BYTE_ZERO;
    write_acc = 1'b0;
    write_file = 1'b0;
    set_zero = 1'b0;
    set_carry = 1'b0;
    carry_value = 1'b0;
    branch = 1'b0;
    skip = 1'b0;
    if (take) begin
      if (instr_word[core_exec_pkg::BR_MSB:core_exec_pkg::BR_LSB]
          == core_exec_pkg::OP_ABSOLUTE_BRANCH) begin
        branch = 1'b1;
      end else begin
        unique case (opcode)
          core_exec_pkg::OP_FILE_INCREMENT: begin
            result = operand + core_exec_pkg::BYTE_ONE;
            write_acc = !dest_file;
            write_file = dest_file;
            set_zero = 1'b1;
          end
          core_exec_pkg::OP_INCREMENT_SKIP_ZERO: begin
            result = operand + core_exec_pkg::BYTE_ONE;
            write_acc = !dest_file;
            write_file = dest_file;
            skip = (result == core_exec_pkg::BYTE_ZERO);
          end
          core_exec_pkg::OP_OR_ACCUMULATOR_FILE: begin
            result = acc_reg | operand;
            write_acc = !dest_file;
            write_file = dest_file;
            set_zero = 1'b1;
          end
          core_exec_pkg::OP_LOGICAL_LEFT_SHIFT: begin
            result = {operand[6:0], 1'b0};
            carry_value = operand[7];
            set_carry = 1'b1;
            write_acc = !dest_file;
            write_file = dest_file;
            set_zero = 1'b1;
          end
          core_exec_pkg::OP_OR_LITERAL_ACCUMULATOR: begin
            result = acc_reg | instr_word[core_exec_pkg::LIT8_MSB:0];
            write_acc = 1'b1;
            set_zero = 1'b1;
          end
          default: begin
            result = core_exec_pkg::BYTE_ZERO;
          end
        endcase
      end
    end
  end

  // ****************************************
  // program counter next value
  // ****************************************
  always_comb begin
    pc_next = pc_reg;
    if (branch) begin
      pc_next[core_exec_pkg::LIT11_MSB:0] = instr_word[core_exec_pkg::LIT11_MSB:0];
      pc_next[14:11] = latch_reg[core_exec_pkg::LATCH_HI:core_exec_pkg::LATCH_LO];
    end else if (skip) begin
      pc_next = pc_reg + core_exec_pkg::PC_SKIP_STEP;
    end else if (take) begin
      pc_next = pc_reg + core_exec_pkg::PC_STEP;
    end
  end

  always_comb begin
    state_next = core_exec_pkg::EXEC_STATE;
    unique case (state_reg)
      core_exec_pkg::EXEC_STATE: begin
        if (branch || skip) begin
          state_next = core_exec_pkg::FLUSH_STATE;
        end
      end
      core_exec_pkg::FLUSH_STATE: begin
        state_next = core_exec_pkg::EXEC_STATE;
      end
    endcase
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= core_exec_pkg::EXEC_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == core_exec_pkg::EXEC_STATE);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= take;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_reg <= core_exec_pkg::PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // ****************************************
  // accumulator, flags and latch
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= core_exec_pkg::ACC_RESET;
    end else if (write_acc) begin
      acc_reg <= result;
    end else if (bus_wr_acc) begin
      acc_reg <= bus_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      zero_reg <= 1'b0;
    end else if (set_zero) begin
      zero_reg <= (result == core_exec_pkg::BYTE_ZERO);
    end else if (bus_wr_status) begin
      zero_reg <= bus_wdata[core_exec_pkg::STATUS_ZERO_POS];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      carry_reg <= 1'b0;
    end else if (set_carry) begin
      carry_reg <= carry_value;
    end else if (bus_wr_status) begin
      carry_reg <= bus_wdata[core_exec_pkg::STATUS_CARRY_POS];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_reg <= core_exec_pkg::LATCH_RESET;
    end else if (bus_wr_latch) begin
      latch_reg <= bus_wdata[6:0];
    end
  end

  // ****************************************
  // file register space
  // ****************************************
  always_ff @(posedge clk) begin
    if (write_file) begin
      file_mem[file_addr] <= result;
    end else if (bus_wr_file) begin
      file_mem[bus_addr[6:0]] <= bus_wdata;
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_comb begin
    read_value = core_exec_pkg::BYTE_ZERO;
    if (bus_addr <= core_exec_pkg::ADDR_FILE_LAST) begin
      read_value = file_mem[bus_addr[6:0]];
    end else begin
      unique case (bus_addr)
        core_exec_pkg::ADDR_ACCUMULATOR: read_value = acc_reg;
        core_exec_pkg::ADDR_STATUS: read_value = {6'h00, zero_reg, carry_reg};
        core_exec_pkg::ADDR_PC_LATCH: read_value = {1'b0, latch_reg};
        core_exec_pkg::ADDR_PC_LOW: read_value = pc_reg[7:0];
        core_exec_pkg::ADDR_PC_HIGH: read_value = {1'b0, pc_reg[14:8]};
        default: read_value = core_exec_pkg::BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= core_exec_pkg::BYTE_ZERO;
    end else if (bus_rd) begin
      rdata_reg <= read_value;
    end else begin
      rdata_reg <= core_exec_pkg::BYTE_ZERO;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign instr_ready = ready_reg;
  assign instr_done = done_reg;
  assign bus_rdata = rdata_reg;
  assign program_counter = pc_reg;
  assign accumulator = acc_reg;
  assign carry_flag = carry_reg;
  assign zero_flag = zero_reg;

endmodule
`default_nettype wire
